// ===== hw/bzo_defines.svh
// Register offsets, field positions, reset values and timing counts of the tone block
// How it works
// R1: The tone square wave runs only while the tone enable bit (bit 1 of aux_control_one) is set.
// R2: The tone square wave leaves on port 1 bit 0, the tone pin.
// R3: A 6-bit software-writable divisor sets the tone frequency.
// R4: Tone frequency is the clock divided by 256 times (divisor plus one).
// R5: With the tone off the generator output rests high, so an active-low buzzer is silent.
// R6: With the reset-level strap high, the tone pin is high from reset onward.
// R7: For an active-high buzzer software clears the port latch early after startup.
// R8: To start an active-high buzzer software sets the enable bit, then the port latch.
// R9: To stop an active-high buzzer software clears the port latch, then the enable bit.
// R10: The pin carries the tone only while both the enable bit and the port latch are set.
`ifndef BZO_DEFINES_SVH
`define BZO_DEFINES_SVH
`define BZO_AUX_CONTROL_ONE_OFF 12'h000
`define BZO_TONE_CONTROL_OFF    12'h004
`define BZO_PORT1_LATCH_OFF     12'h008
`define BZO_STATUS_OFF          12'h00c
`define BZO_TONE_ENABLE_BIT     1
`define BZO_TONE_PIN_BIT        0
`define BZO_DIV_W               6
`define BZO_PRESCALE            256
`define BZO_HALF_PRESCALE       8'h7f
`define BZO_AUX_RST             8'h00
`define BZO_DIV_RST             6'h00
`define BZO_LATCH_RST           8'hff
`define BZO_HALF_UNIT           128
`endif

// ===== hw/bzo_pkg.sv
// Types shared by the tone block
package bzo_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } bzo_apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } bzo_apb_rsp_t;
endpackage

// ===== hw/bzo_tone.sv
// Buzzer square-wave generator with APB register access
`timescale 1ns/1ps
`include "bzo_defines.svh"
module bzo_tone
(
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire bzo_pkg::bzo_apb_req_t apb_req,
  output      bzo_pkg::bzo_apb_rsp_t apb_rsp,
  // Reset-level strap
  input  wire logic                  port_reset_level_high,
  // Tone pin
  output      logic                  tone_pin,
  output      logic                  tone_pin_oe
);
  logic [7:0]                 aux_control_one_ff, nxt_aux_control_one;
  logic [`BZO_DIV_W-1:0]      tone_divisor_ff, nxt_tone_divisor;
  logic [7:0]                 port1_latch_ff, nxt_port1_latch;
  logic                       latch_init_ff, nxt_latch_init;
  logic [7:0]                 pre_cnt_ff, nxt_pre_cnt;
  logic [`BZO_DIV_W-1:0]      div_cnt_ff, nxt_div_cnt;
  logic                       wave_ff, nxt_wave;
  logic                       pin_ff, nxt_pin;
  bzo_pkg::bzo_apb_rsp_t      rsp_ff, nxt_rsp;
  logic                       tone_enable;
  logic                       acc, wr;

  assign tone_enable = aux_control_one_ff[`BZO_TONE_ENABLE_BIT];  // see R1
  assign acc         = apb_req.psel && apb_req.penable;
  assign wr          = acc && apb_req.pwrite;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `BZO_AUX_CONTROL_ONE_OFF) || (a == `BZO_TONE_CONTROL_OFF) ||
             (a == `BZO_PORT1_LATCH_OFF) || (a == `BZO_STATUS_OFF);
  endfunction

  // Registers and bus answer; zero-wait slave, pready in the access cycle
  always_comb
  begin
    nxt_aux_control_one = aux_control_one_ff;
    nxt_tone_divisor    = tone_divisor_ff;
    nxt_port1_latch     = port1_latch_ff;
    nxt_latch_init      = 1'b1;
    nxt_rsp             = '0;
    // Latch follows the strap once after reset release
    if (!latch_init_ff)
    begin
      nxt_port1_latch = {8{port_reset_level_high}};  // see R6
    end
    else if (wr)
    begin
      case (apb_req.paddr)
        `BZO_AUX_CONTROL_ONE_OFF: nxt_aux_control_one = apb_req.pwdata[7:0];
        `BZO_TONE_CONTROL_OFF:    nxt_tone_divisor = apb_req.pwdata[`BZO_DIV_W-1:0];  // see R3
        `BZO_PORT1_LATCH_OFF:     nxt_port1_latch = apb_req.pwdata[7:0];
        default:                  ;
      endcase
    end
    if (apb_req.psel && !apb_req.penable)
    begin
      nxt_rsp.pready  = 1'b1;
      nxt_rsp.pslverr = !mapped(apb_req.paddr);
      if (!apb_req.pwrite)
      begin
        case (apb_req.paddr)
          `BZO_AUX_CONTROL_ONE_OFF: nxt_rsp.prdata = {24'h000000, aux_control_one_ff};
          `BZO_TONE_CONTROL_OFF:    nxt_rsp.prdata = {26'h0, tone_divisor_ff};
          `BZO_PORT1_LATCH_OFF:     nxt_rsp.prdata = {24'h000000, port1_latch_ff};
          `BZO_STATUS_OFF:          nxt_rsp.prdata = {30'h0, pin_ff, wave_ff};
          default:                  nxt_rsp.prdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_control_one_ff <= `BZO_AUX_RST;
      tone_divisor_ff    <= `BZO_DIV_RST;
      port1_latch_ff     <= `BZO_LATCH_RST;
      latch_init_ff      <= 1'b0;
      rsp_ff             <= '0;
    end
    else
    begin
      aux_control_one_ff <= nxt_aux_control_one;
      tone_divisor_ff    <= nxt_tone_divisor;
      port1_latch_ff     <= nxt_port1_latch;
      latch_init_ff      <= nxt_latch_init;
      rsp_ff             <= nxt_rsp;
    end
  end

  // Divider: toggle every 128 x (div+1) clocks, period 256 x (div+1)
  always_comb
  begin
    nxt_pre_cnt = pre_cnt_ff;
    nxt_div_cnt = div_cnt_ff;
    nxt_wave    = wave_ff;
    if (!tone_enable)
    begin
      nxt_pre_cnt = 8'h00;
      nxt_div_cnt = '0;
      nxt_wave    = 1'b1;  // see R5
    end
    else if (pre_cnt_ff != `BZO_HALF_PRESCALE)
    begin
      nxt_pre_cnt = pre_cnt_ff + 8'h01;
    end
    else
    begin
      nxt_pre_cnt = 8'h00;
      if (div_cnt_ff >= tone_divisor_ff)
      begin
        nxt_div_cnt = '0;
        nxt_wave    = !wave_ff;  // see R4
      end
      else
      begin
        nxt_div_cnt = div_cnt_ff + 6'h01;
      end
    end
    // Pin is latch AND wave; off state high when latch high
    nxt_pin = port1_latch_ff[`BZO_TONE_PIN_BIT] && wave_ff;  // see R2
    if (!latch_init_ff)
    begin
      nxt_pin = port_reset_level_high;  // see R6
    end
  end

  // Pin resets high: strap default assumed high until sampled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_cnt_ff <= 8'h00;
      div_cnt_ff <= '0;
      wave_ff    <= 1'b1;
      pin_ff     <= 1'b1;
    end
    else
    begin
      pre_cnt_ff <= nxt_pre_cnt;
      div_cnt_ff <= nxt_div_cnt;
      wave_ff    <= nxt_wave;
      pin_ff     <= nxt_pin;  // see R10
    end
  end

  assign apb_rsp     = rsp_ff;
  assign tone_pin    = pin_ff;
  assign tone_pin_oe = latch_init_ff;

  // Helper for the half-period check only; it drives no output
  logic [13:0]                half_cnt_ff, nxt_half_cnt;

  always_comb
  begin
    nxt_half_cnt = half_cnt_ff + 14'h0001;
    // Restart at every wave edge and while the generator rests
    if (!tone_enable || wave_ff != nxt_wave)
    begin
      nxt_half_cnt = 14'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      half_cnt_ff <= 14'h0000;
    end
    else
    begin
      half_cnt_ff <= nxt_half_cnt;
    end
  end

  sequence tone_off_s;
    !tone_enable ##1 !tone_enable;
  endsequence

  wave_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    tone_off_s |-> wave_ff) else $error("wave not high while disabled");
  wave_idle_hi_a: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    !tone_enable |=> wave_ff) else $error("generator off state not high");
  half_period_a: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    (tone_enable && $past(tone_enable) && wave_ff != nxt_wave && half_cnt_ff != 14'h0000)
    |-> half_cnt_ff == 14'(`BZO_HALF_UNIT * ({8'h00, tone_divisor_ff} + 14'h0001) - 1))
    else $error("tone half period wrong");
  pin_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    latch_init_ff |=> pin_ff == ($past(port1_latch_ff[0]) && $past(wave_ff)))
    else $error("pin not latch and wave");
  pin_low_a: assert property (@(posedge pclk) disable iff (!presetn) // see R2
    (latch_init_ff && !port1_latch_ff[0]) |=> !pin_ff) else $error("pin high with latch low");
  strap_a: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    (!latch_init_ff && port_reset_level_high) |=> pin_ff && port1_latch_ff[0])
    else $error("strap level not applied");
  div_store_a: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    (latch_init_ff && wr && apb_req.paddr == `BZO_TONE_CONTROL_OFF)
    |=> tone_divisor_ff == $past(apb_req.pwdata[5:0])) else $error("divisor not stored");
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_req.psel && !apb_req.penable) |=> apb_rsp.pready) else $error("no pready");

  // Bus phases as this slave sees them
  sequence apb_setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence

  sequence apb_access_s;
    apb_req.psel && apb_req.penable;
  endsequence

  // Generator leaves rest; its first half period starts from clean counters
  sequence tone_start_s;
    !tone_enable ##1 tone_enable;
  endsequence

  pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s ##1 apb_access_s
    |-> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("pready not a single pulse");

  err_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_req.psel && !apb_req.penable && !mapped(apb_req.paddr))
    |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h00000000)
    else $error("unmapped access not refused");

  err_mapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_req.psel && !apb_req.penable && mapped(apb_req.paddr))
    |=> !apb_rsp.pslverr)
    else $error("mapped access refused");

  read_aux_a: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    (apb_req.psel && !apb_req.penable && !apb_req.pwrite &&
     apb_req.paddr == `BZO_AUX_CONTROL_ONE_OFF)
    |=> apb_rsp.prdata == {24'h000000, $past(aux_control_one_ff)})
    else $error("aux read data wrong");

  read_div_a: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    (apb_req.psel && !apb_req.penable && !apb_req.pwrite &&
     apb_req.paddr == `BZO_TONE_CONTROL_OFF)
    |=> apb_rsp.prdata == {26'h0, $past(tone_divisor_ff)})
    else $error("divisor read data wrong");

  read_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    (apb_req.psel && !apb_req.penable && !apb_req.pwrite &&
     apb_req.paddr == `BZO_PORT1_LATCH_OFF)
    |=> apb_rsp.prdata == {24'h000000, $past(port1_latch_ff)})
    else $error("latch read data wrong");

  read_status_a: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    (apb_req.psel && !apb_req.penable && !apb_req.pwrite &&
     apb_req.paddr == `BZO_STATUS_OFF)
    |=> apb_rsp.prdata == {30'h0, $past(pin_ff), $past(wave_ff)})
    else $error("status read data wrong");

  aux_store_a: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    (latch_init_ff && wr && apb_req.paddr == `BZO_AUX_CONTROL_ONE_OFF)
    |=> aux_control_one_ff == $past(apb_req.pwdata[7:0]))
    else $error("aux control not stored");

  latch_store_a: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    (latch_init_ff && wr && apb_req.paddr == `BZO_PORT1_LATCH_OFF)
    |=> port1_latch_ff == $past(apb_req.pwdata[7:0]))
    else $error("port latch not stored");

  bad_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (latch_init_ff && wr && !mapped(apb_req.paddr))
    |=> $stable(aux_control_one_ff) && $stable(tone_divisor_ff) && $stable(port1_latch_ff))
    else $error("unmapped write changed a register");

  // Divider steps; a lowered divisor takes effect at the next prescaler wrap, even mid-count
  tone_start_a: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    tone_start_s
    |-> wave_ff && pre_cnt_ff == 8'h00 && div_cnt_ff == 6'h00)
    else $error("tone did not start from rest");

  wave_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    (tone_enable && pre_cnt_ff != `BZO_HALF_PRESCALE)
    |=> wave_ff == $past(wave_ff))
    else $error("wave moved between prescaler wraps");

  pre_bound_a: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    tone_enable
    |-> pre_cnt_ff <= `BZO_HALF_PRESCALE)
    else $error("prescaler past its wrap");

  wave_step_a: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    (tone_enable && pre_cnt_ff == `BZO_HALF_PRESCALE && div_cnt_ff < tone_divisor_ff)
    |=> wave_ff == $past(wave_ff) && div_cnt_ff == $past(div_cnt_ff) + 6'h01)
    else $error("divider step wrong");

  wave_flip_a: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    (tone_enable && pre_cnt_ff == `BZO_HALF_PRESCALE && div_cnt_ff >= tone_divisor_ff)
    |=> wave_ff != $past(wave_ff) && div_cnt_ff == 6'h00)
    else $error("wave did not toggle at half period end");

  pin_rest_a: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    (latch_init_ff && !tone_enable && port1_latch_ff[`BZO_TONE_PIN_BIT])
    ##1 (!tone_enable && port1_latch_ff[`BZO_TONE_PIN_BIT])
    |=> pin_ff)
    else $error("pin not high at rest");

  strap_low_a: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    (!latch_init_ff && !port_reset_level_high)
    |=> !pin_ff && port1_latch_ff == 8'h00)
    else $error("low strap level not applied");
endmodule // bzo_tone

// ===== tb/bzo_buzzer.sv
// Buzzer transducer model that times the tone pin
`timescale 1ns/1ps
module bzo_buzzer
(
  // Clock
  input  wire logic pclk,
  // Pin level
  input  wire logic pin,
  // Measured tone
  output      int   period,
  output      int   rises
);
  int   cnt = 0;
  logic last = 1'b1;
  // Period counts full cycles between rising edges
  always @(posedge pclk)
  begin
    cnt <= cnt + 1;
    last <= pin;
    if (pin && !last)
    begin
      period <= cnt + 1;
      rises <= rises + 1;
      cnt <= 0;
    end
  end
endmodule // bzo_buzzer

// ===== tb/bzo_tone_tb.sv
// Self-checking bench of the tone block
`timescale 1ns/1ps
`include "bzo_defines.svh"
module bzo_tone_tb;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  strap = 1'b1;
  bzo_pkg::bzo_apb_req_t req = '0;
  bzo_pkg::bzo_apb_rsp_t rsp;
  logic                  pin_o;
  logic                  pin_oe;
  wire                   pin = pin_oe ? pin_o : 1'b1;
  int                    period;
  int                    rises;
  int                    failures = 0;
  int                    total_checks = 0;
  logic [31:0]           rdat;
  logic                  rerr;
  always #5 pclk = ~pclk;
  bzo_tone dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .port_reset_level_high(strap), .tone_pin(pin_o), .tone_pin_oe(pin_oe));
  bzo_buzzer bz (.pclk(pclk), .pin(pin), .period(period), .rises(rises));
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (rsp.pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      failures++;
      close_out();
    end
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req <= '0;
  endtask
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk("aux", 32'h0, rdat);
    chk("aux err", 32'h0, rerr);
    apb(1'b0, 12'h008, 32'h0);
    chk("latch", 32'hff, rdat);
    apb(1'b1, 12'h004, 32'hff);
    apb(1'b0, 12'h004, 32'h0);
    chk("divisor", 32'h3f, rdat);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {rdat[30:0], rerr});
    apb(1'b1, 12'h010, 32'h2);
    chk("bad write err", 32'h1, rerr);
    apb(1'b0, 12'h000, 32'h0);
    chk("aux kept", 32'h0, rdat);
    $display("register test done");
  endtask
  task automatic t_tone(input logic [5:0] d);
    int r0;
    int n;
    apb(1'b1, 12'h004, {26'h0, d});
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b1, 12'h008, 32'hff);
    r0 = rises;
    for (n = 0; n < 4000 && rises < r0 + 3; n++)
      @(posedge pclk);
    if (rises < r0 + 3)
    begin
      failures++;
      close_out();
    end
    chk("period", `BZO_PRESCALE * (d + 1), period);
    $display("tone test done");
  endtask
  task automatic t_stop;
    int r0;
    apb(1'b1, 12'h008, 32'hfe);
    repeat (3) @(posedge pclk);
    chk("pin latch low", 32'h0, pin_o);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h008, 32'hff);
    r0 = rises;
    repeat (600) @(posedge pclk);
    chk("pin off", 32'h1, pin_o);
    chk("no tone", r0 + 1, rises);
    apb(1'b0, 12'h00c, 32'h0);
    chk("status", 32'h3, rdat);
    $display("stop test done");
  endtask
  task automatic t_reset;
    repeat (20) @(posedge pclk);
    chk("reset pin", 32'h1, pin_o);
    chk("reset oe", 32'h0, pin_oe);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("strap pin", 32'h3, {pin_o, pin_oe});
    $display("reset test done");
  endtask
  task automatic t_quiet;
    apb(1'b1, 12'h008, 32'hfe);
    repeat (300) @(posedge pclk);
    chk("quiet pin", 32'h0, pin_o);
    $display("quiet test done");
  endtask
  // Mid-run reset with the strap low: pin and latch must come up low
  task automatic t_strap_low;
    @(posedge pclk);
    presetn <= 1'b0;
    strap   <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("low strap pin", 32'h1, {pin_o, pin_oe});
    apb(1'b0, 12'h008, 32'h0);
    chk("low strap latch", 32'h0, rdat);
    $display("strap test done");
  endtask
  initial
  begin
    t_reset();
    t_regs();
    t_quiet();
    t_tone(6'h00);
    t_tone(6'h02);
    t_stop();
    t_strap_low();
    close_out();
  end
endmodule // bzo_tone_tb
